// >>> shared/ref_ctrl_pkg.sv
// register map, field positions, encodings and timing for the reference and
// temperature indicator control block; assumes an 8-bit software port
package ref_ctrl_pkg;

	// ==========================================================
	// register offsets
	localparam logic [15:0] CTRL_OFFSET      = 16'h020c;
	localparam logic [15:0] INT_STATUS_OFFSET = 16'h0210;
	localparam logic [15:0] INT_MASK_OFFSET  = 16'h0211;

	// ==========================================================
	// field positions of the control register
	localparam int REF_ENABLE_BIT  = 7;
	localparam int READY_BIT       = 6;
	localparam int TEMP_ON_BIT     = 5;
	localparam int TEMP_RANGE_BIT  = 4;
	localparam int BUF2_GAIN_LSB   = 2;
	localparam int BUF1_GAIN_LSB   = 0;

	// interrupt status bit positions
	localparam int IRQ_READY_RISE_BIT = 0;
	localparam int IRQ_READY_FALL_BIT = 1;

	// ==========================================================
	// reset values
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [1:0] IRQ_RESET   = 2'h0;

	// ==========================================================
	// gain encodings of a reference buffer
	typedef enum logic [1:0] {
		GAIN_OFF = 2'b00,
		GAIN_1X  = 2'b01,
		GAIN_2X  = 2'b10,
		GAIN_4X  = 2'b11
	} gain_t;

	// ==========================================================
	// settle time before the stability report is trusted
	localparam int SETTLE_NS     = 25000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// >>> logic/buffer_gain_decode.sv
// decodes one 2-bit buffer gain field into on and gain-select strobes
// assumes a field from the control register on the same clock
`timescale 1ns/100ps
module buffer_gain_decode (
	input  wire logic [1:0] gain_field,
	output logic            buf_on,
	output logic [2:0]      gain_onehot
);
	// ==========================================================
	// decode: one-hot {4x,2x,1x}, all zero when the buffer is off
	always_comb begin
		buf_on      = 1'b1;
		gain_onehot = 3'b000;
		case (ref_ctrl_pkg::gain_t'(gain_field))
			ref_ctrl_pkg::GAIN_4X: gain_onehot = 3'b100;
			ref_ctrl_pkg::GAIN_2X: gain_onehot = 3'b010;
			ref_ctrl_pkg::GAIN_1X: gain_onehot = 3'b001;
			default: buf_on = 1'b0;
		endcase
	end
endmodule

// >>> logic/reference_control.sv
// control, ready tracking and interrupts for a fixed voltage reference with two
// gain buffers and a die temperature indicator
// assumes an analog stability report from another domain and an 8-bit software port
// register map, every register 8 bits wide:
//   control     enable, ready (read-only), sensor on, range, two buffer gains
//   int status  sticky ready rise in bit 0 and ready fall in bit 1
//   int mask    same layout as int status; a set bit lets its event drive IRQ
// reading int status clears it; an event in that same cycle survives the clear
// unmapped reads return zero and unmapped writes are dropped
//
// the stability report arrives from the analog domain and passes two flops;
// everything else lives on CLK with the asynchronous active-low RST_B
//
// limitation: ready waits a fixed settle count as well as the report, so a
// report that is already high when the reference turns on is not trusted
// until the count has run out
//
// the gain fields keep their values while the reference is off, but both
// buffers and all their routes are held off until the reference is on again
// the temperature sensor does not depend on the reference enable
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module reference_control (
	input  wire logic       CLK,
	input  wire logic       RST_B,
	input  wire logic [15:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic [7:0]      RDATA,
	input  wire logic       ANALOG_STABLE,
	output logic            REF_ON,
	output logic            TEMP_SENSOR_ON,
	output logic            TEMP_RANGE_HIGH,
	output logic            BUF2_ON,
	output logic [2:0]      BUF2_GAIN_SEL,
	output logic            BUF2_TO_DAC,
	output logic            BUF2_TO_CMP,
	output logic            BUF2_TO_ADC_CHAN,
	output logic            BUF1_ON,
	output logic [2:0]      BUF1_GAIN_SEL,
	output logic            BUF1_TO_ADC_REF,
	output logic            BUF1_TO_ADC_CHAN,
	output logic            IRQ
);
	// ==========================================================
	// storage
	// control register fields
	logic        ref_enable_reg;
	logic        temp_on_reg;
	logic        temp_range_reg;
	logic [1:0]  buf2_gain_reg;
	logic [1:0]  buf1_gain_reg;

	// ready tracking
	logic        ready_reg;
	logic        ready_next;
	logic        stable_meta_reg;
	logic        stable_sync_reg;
	logic [15:0] settle_cnt_reg;

	// interrupts
	logic [1:0]  irq_status_reg;
	logic [1:0]  irq_mask_reg;
	logic [1:0]  irq_event;

	// access decode and wiring
	logic        wr_ctrl;
	logic        wr_mask;
	logic        rd_ctrl;
	logic        rd_status;
	logic        rd_mask;
	logic [7:0]  ctrl_view;
	logic        buf2_on_w;
	logic        buf1_on_w;
	logic [2:0]  buf2_sel_w;
	logic [2:0]  buf1_sel_w;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == off);
	endfunction

	// a buffer only passes a gain select while the reference core runs
	function automatic logic [2:0] gate_sel(input logic en, input logic [2:0] sel);
		gate_sel = en ? sel : 3'b000;
	endfunction

	// ==========================================================
	// access decode: exact match only, so aliases of the map stay silent
	// the bus never waits, so every strobe is acted on in its own cycle
	assign wr_ctrl   = WR && hit(ADDR, ref_ctrl_pkg::CTRL_OFFSET);
	assign wr_mask   = WR && hit(ADDR, ref_ctrl_pkg::INT_MASK_OFFSET);
	assign rd_ctrl   = RD && hit(ADDR, ref_ctrl_pkg::CTRL_OFFSET);
	assign rd_status = RD && hit(ADDR, ref_ctrl_pkg::INT_STATUS_OFFSET); // clear-on-read strobe
	assign rd_mask   = RD && hit(ADDR, ref_ctrl_pkg::INT_MASK_OFFSET);

	// ==========================================================
	// control register fields, one process each; the ready position is
	// never stored, so a write there has nothing to land in

	// reference enable
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ref_enable_reg <= ref_ctrl_pkg::CTRL_RESET[ref_ctrl_pkg::REF_ENABLE_BIT];
		end else if (wr_ctrl) begin
			ref_enable_reg <= WDATA[ref_ctrl_pkg::REF_ENABLE_BIT];
		end
	end

	// temperature sensor enable
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			temp_on_reg <= ref_ctrl_pkg::CTRL_RESET[ref_ctrl_pkg::TEMP_ON_BIT];
		end else if (wr_ctrl) begin
			temp_on_reg <= WDATA[ref_ctrl_pkg::TEMP_ON_BIT];
		end
	end

	// temperature range select
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			temp_range_reg <= ref_ctrl_pkg::CTRL_RESET[ref_ctrl_pkg::TEMP_RANGE_BIT];
		end else if (wr_ctrl) begin
			temp_range_reg <= WDATA[ref_ctrl_pkg::TEMP_RANGE_BIT];
		end
	end

	// buffer two gain field
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			buf2_gain_reg <= ref_ctrl_pkg::CTRL_RESET[ref_ctrl_pkg::BUF2_GAIN_LSB +: 2];
		end else if (wr_ctrl) begin
			buf2_gain_reg <= WDATA[ref_ctrl_pkg::BUF2_GAIN_LSB +: 2];
		end
	end

	// buffer one gain field
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			buf1_gain_reg <= ref_ctrl_pkg::CTRL_RESET[ref_ctrl_pkg::BUF1_GAIN_LSB +: 2];
		end else if (wr_ctrl) begin
			buf1_gain_reg <= WDATA[ref_ctrl_pkg::BUF1_GAIN_LSB +: 2];
		end
	end

	// ==========================================================
	// stability report comes from the analog domain, so synchronise it
	// first stage: may go metastable, only ever feeds the second stage
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			stable_meta_reg <= 1'b0;
		end else begin
			stable_meta_reg <= ANALOG_STABLE;
		end
	end

	// second stage: the only copy the rest of the logic reads
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			stable_sync_reg <= 1'b0;
		end else begin
			stable_sync_reg <= stable_meta_reg;
		end
	end

	// ==========================================================
	// settle counter: a stale stable report right after enable is not trusted
	// the count saturates, so ready holds for as long as the report stays high
	// sixteen bits cover the settle count with room to spare
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			settle_cnt_reg <= 16'h0000;
		end else if (!ref_enable_reg) begin
			settle_cnt_reg <= 16'h0000;
		end else if (settle_cnt_reg < 16'(ref_ctrl_pkg::SETTLE_CYCLES)) begin
			settle_cnt_reg <= settle_cnt_reg + 16'h0001;
		end
	end

	// ready: enabled, settled and reported stable
	always_comb begin
		ready_next = ref_enable_reg && stable_sync_reg
			&& (settle_cnt_reg == 16'(ref_ctrl_pkg::SETTLE_CYCLES));
	end

	// registered so the read view and both edge events see one settled value
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ready_reg <= 1'b0;
		end else begin
			ready_reg <= ready_next;
		end
	end

	// ==========================================================
	// interrupts: ready rise and fall are sticky; a set in the clearing read wins
	always_comb begin
		irq_event                                   = 2'b00;
		irq_event[ref_ctrl_pkg::IRQ_READY_RISE_BIT] = !ready_reg && ready_next;
		irq_event[ref_ctrl_pkg::IRQ_READY_FALL_BIT] = ready_reg && !ready_next;
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			irq_status_reg <= ref_ctrl_pkg::IRQ_RESET;
		end else if (rd_status) begin
			irq_status_reg <= irq_event;
		end else begin
			irq_status_reg <= irq_status_reg | irq_event;
		end
	end

	// mask is plain read/write; it never touches the sticky bits
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			irq_mask_reg <= ref_ctrl_pkg::IRQ_RESET;
		end else if (wr_mask) begin
			irq_mask_reg <= WDATA[1:0];
		end
	end

	assign IRQ = |(irq_status_reg & irq_mask_reg);

	// ==========================================================
	// read path: data stands the cycle after the strobe, unmapped reads zero
	// control view; the ready bit is the tracker's, never what software wrote
	always_comb begin
		ctrl_view                                   = 8'h00;
		ctrl_view[ref_ctrl_pkg::REF_ENABLE_BIT]     = ref_enable_reg;
		ctrl_view[ref_ctrl_pkg::READY_BIT]          = ready_reg;
		ctrl_view[ref_ctrl_pkg::TEMP_ON_BIT]        = temp_on_reg;
		ctrl_view[ref_ctrl_pkg::TEMP_RANGE_BIT]     = temp_range_reg;
		ctrl_view[ref_ctrl_pkg::BUF2_GAIN_LSB +: 2] = buf2_gain_reg;
		ctrl_view[ref_ctrl_pkg::BUF1_GAIN_LSB +: 2] = buf1_gain_reg;
	end

	// zero outside the read cycle, so a stale word never looks like an answer
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			RDATA <= 8'h00;
		end else if (rd_ctrl) begin
			RDATA <= ctrl_view;
		end else if (rd_status) begin
			RDATA <= {6'h00, irq_status_reg};
		end else if (rd_mask) begin
			RDATA <= {6'h00, irq_mask_reg};
		end else begin
			RDATA <= 8'h00;
		end
	end

	// ==========================================================
	// buffer gain decoders
	buffer_gain_decode u_buf2 (
		.gain_field  (buf2_gain_reg),
		.buf_on      (buf2_on_w),
		.gain_onehot (buf2_sel_w)
	);

	buffer_gain_decode u_buf1 (
		.gain_field  (buf1_gain_reg),
		.buf_on      (buf1_on_w),
		.gain_onehot (buf1_sel_w)
	);

	// ==========================================================
	// analog controls; buffers only run while the reference core is on
	// reference and temperature sensor
	assign REF_ON          = ref_enable_reg;
	assign TEMP_SENSOR_ON  = temp_on_reg;
	assign TEMP_RANGE_HIGH = temp_range_reg;

	// buffers: decoded gain, gated by the reference enable
	assign BUF2_ON         = ref_enable_reg && buf2_on_w;
	assign BUF2_GAIN_SEL   = gate_sel(ref_enable_reg, buf2_sel_w);
	assign BUF1_ON         = ref_enable_reg && buf1_on_w;
	assign BUF1_GAIN_SEL   = gate_sel(ref_enable_reg, buf1_sel_w);

	// routing: buffer two never reaches the converter reference
	assign BUF2_TO_DAC      = BUF2_ON;
	assign BUF2_TO_CMP      = BUF2_ON;
	assign BUF2_TO_ADC_CHAN = BUF2_ON;
	assign BUF1_TO_ADC_REF  = BUF1_ON;
	assign BUF1_TO_ADC_CHAN = BUF1_ON;

	// ==========================================================
	// a report that drops while enabled clears ready and raises the fall
	// event; software treats that as a lost reference, the block just reports it

endmodule

// >>> tb/ref_checks_assertions.sv
// checker for the reference control block
// assumes it is bound to reference_control and sees its ports only
`timescale 1ns/100ps
module ref_checks (
	input wire logic        CLK,
	input wire logic        RST_B,
	input wire logic [15:0] ADDR,
	input wire logic [7:0]  WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [7:0]  RDATA,
	input wire logic        REF_ON,
	input wire logic        TEMP_SENSOR_ON,
	input wire logic        TEMP_RANGE_HIGH,
	input wire logic        BUF2_ON,
	input wire logic [2:0]  BUF2_GAIN_SEL,
	input wire logic        BUF2_TO_DAC,
	input wire logic        BUF1_ON,
	input wire logic [2:0]  BUF1_GAIN_SEL,
	input wire logic        BUF1_TO_ADC_REF,
	input wire logic        IRQ
);
	// ==========
	// one clock domain, so clocking and reset are given once
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	logic wc;
	// a write aimed at the control register
	assign wc = WR && ADDR == ref_ctrl_pkg::CTRL_OFFSET;
	// ==========
	// properties
	property p_ref; wc |=> REF_ON == $past(WDATA[7]); endproperty
	a_ref: assert property (p_ref) else $error("enable bit not applied");
	property p_ts; wc |=> TEMP_SENSOR_ON == $past(WDATA[5]); endproperty
	a_ts: assert property (p_ts) else $error("sensor enable not applied");
	property p_rng; wc |=> TEMP_RANGE_HIGH == $past(WDATA[4]); endproperty
	a_rng: assert property (p_rng) else $error("range bit not applied");
	property p_b2; BUF2_ON == (|BUF2_GAIN_SEL) && $onehot0(BUF2_GAIN_SEL) && BUF2_TO_DAC == BUF2_ON; endproperty
	a_b2: assert property (p_b2) else $error("buffer two decode wrong");
	property p_b1; BUF1_ON == (|BUF1_GAIN_SEL) && $onehot0(BUF1_GAIN_SEL) && BUF1_TO_ADC_REF == BUF1_ON; endproperty
	a_b1: assert property (p_b1) else $error("buffer one decode wrong");
	// buffers are held off while the reference itself is off
	property p_off; !REF_ON |-> !BUF1_ON && !BUF2_ON; endproperty
	a_off: assert property (p_off) else $error("buffer on without reference");
	property p_rdy; RD && ADDR == ref_ctrl_pkg::CTRL_OFFSET && !REF_ON && !$past(REF_ON) |=> !RDATA[6]; endproperty
	a_rdy: assert property (p_rdy) else $error("ready seen while disabled");
	property p_rst; $rose(RST_B) |-> !REF_ON && !IRQ && RDATA == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("outputs not clear after reset");
	c_en: cover property (wc && WDATA[7]);
	c_rdy: cover property (RD && ADDR == ref_ctrl_pkg::CTRL_OFFSET ##1 RDATA[6]);
	c_irq: cover property ($rose(IRQ));
endmodule
bind reference_control ref_checks ref_checks_inst (.*);

// >>> tb/reference_control_tb.sv
// self-checking bench for reference_control
// assumes the design package is compiled first
`timescale 1ns/100ps
module reference_control_tb;
	// ==========
	// signals
	logic        CLK = 1'h0, RST_B = 1'h0, WR = 1'h0, RD = 1'h0, ANALOG_STABLE = 1'h0;
	logic [15:0] ADDR = 16'h0000;
	logic [7:0]  WDATA = 8'h00, RDATA;
	logic        REF_ON, TEMP_SENSOR_ON, TEMP_RANGE_HIGH, IRQ, BUF2_ON, BUF1_ON;
	logic        BUF2_TO_DAC, BUF2_TO_CMP, BUF2_TO_ADC_CHAN, BUF1_TO_ADC_REF, BUF1_TO_ADC_CHAN;
	logic [2:0]  BUF2_GAIN_SEL, BUF1_GAIN_SEL;
	int          num_errors = 0, compares = 0;
	localparam logic [15:0] CA = ref_ctrl_pkg::CTRL_OFFSET;
	localparam logic [15:0] SA = ref_ctrl_pkg::INT_STATUS_OFFSET;
	localparam logic [15:0] MA = ref_ctrl_pkg::INT_MASK_OFFSET;
	reference_control reference_control_inst (.*);
	// 4 ns clock
	initial begin
		forever #2 CLK = ~CLK;
	end
	// ==========
	// tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// strobes last one cycle; the #1 lets the edge's updates land
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'h1;
		@(posedge CLK);
		WR <= 1'h0;
		#1;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'h1;
		@(posedge CLK);
		RD <= 1'h0;
		#1;
		chk(RDATA, e);
	endtask
	// expected one-hot gain select, zero when the buffer is off
	function automatic logic [2:0] oh(input logic [1:0] g);
		return (g == 2'h0) ? 3'h0 : 3'h1 << (g - 2'h1);
	endfunction
	task automatic complete_run;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// watchdog: the settle wait dominates, about 6500 cycles
	initial begin
		repeat (20000) @(posedge CLK);
		num_errors++;
		complete_run;
	end
	// ==========
	// main sequence
	initial begin
		repeat (3) @(posedge CLK);
		RST_B <= 1'h1;
		ANALOG_STABLE <= 1'h1;
		rd(CA, 8'h00);
		rd(MA, 8'h00);
		chk({4'h0, REF_ON, TEMP_SENSOR_ON, TEMP_RANGE_HIGH, IRQ}, 8'h00);
		wr(CA, 8'h7f);
		rd(CA, 8'h3f);
		chk({4'h0, BUF2_ON, BUF1_ON, TEMP_SENSOR_ON, TEMP_RANGE_HIGH}, 8'h03);
		wr(CA, 8'h20);
		chk({6'h0, TEMP_SENSOR_ON, TEMP_RANGE_HIGH}, 8'h02);
		// every gain code on both buffers; far too short for the settle time
		for (logic [2:0] g = 3'h0; g < 3'h4; g++) begin
			wr(CA, {4'h8, g[1:0], ~g[1:0]});
			chk({5'h0, BUF2_GAIN_SEL}, {5'h0, oh(g[1:0])});
			chk({5'h0, BUF1_GAIN_SEL}, {5'h0, oh(~g[1:0])});
			chk({3'h0, BUF2_TO_DAC, BUF2_TO_CMP, BUF2_TO_ADC_CHAN, BUF1_TO_ADC_REF, BUF1_TO_ADC_CHAN},
				{3'h0, {3{g != 3'h0}}, {2{g != 3'h3}}});
			rd(CA, {4'h8, g[1:0], ~g[1:0]});
		end
		wr(CA, 8'h00);
		wr(SA, 8'hff);
		rd(SA, 8'h00);
		wr(CA, 8'h80);
		repeat (6100) @(posedge CLK);
		rd(CA, 8'h80);
		repeat (300) @(posedge CLK);
		rd(CA, 8'hc0);
		chk({7'h0, IRQ}, 8'h00);
		wr(MA, 8'h03);
		rd(MA, 8'h03);
		chk({7'h0, IRQ}, 8'h01);
		rd(SA, 8'h01);
		rd(SA, 8'h00);
		chk({7'h0, IRQ}, 8'h00);
		@(posedge CLK);
		ANALOG_STABLE <= 1'h0;
		repeat (6) @(posedge CLK);
		rd(CA, 8'h80);
		chk({7'h0, IRQ}, 8'h01);
		rd(SA, 8'h02);
		wr(16'h020d, 8'hff);
		rd(16'h020d, 8'h00);
		rd(CA, 8'h80);
		complete_run;
	end
endmodule
